// ---- srp_pkg.sv ----
// Constants, field layouts and state codes for the standby, reset and prescaler block.
// Assumes one 20 MHz clock that stands in for the oscillator and a synchronous reset.
// How it works
// - The standby instruction puts the device into low-power standby.
// - After the instruction's machine cycle ends, oscillator stops and operation ceases.
// - In external clock mode, standby gates the clock off from all internal logic.
// - Standby keeps program counter, registers and RAM unchanged.
// - Leaving standby by reset restarts from the power-up state.
// - A rising restart pin edge in standby first restarts the oscillator.
// - Eight stable oscillator clocks are counted before the system clock returns.
// - After restart wake-up, execution continues at the retained program counter.
// - Restart pin wake-up works only when its port is strapped as input.
// - Reset low initialises every internal circuit.
// - Prescaler is a 12-bit up-counter on the machine clock, six oscillator periods.
// - Twelve taps divide the machine clock by 2 through 4096.
// - Control bit 2 set halts the prescaler and silences all its clocks.
// - Control bit 2 cleared restarts the prescaler counting from zero.
// - An external interrupt edge in standby is latched and served after release.

package srp_pkg;

  // ==========================================================================
  // Widths and timing
  localparam int unsigned PSC_W       = 12;
  localparam int unsigned MC_DIV      = 6;
  localparam int unsigned WARM_CLKS   = 8;
  localparam int unsigned ADDR_W      = 4;
  localparam int unsigned DATA_W      = 8;

  // ==========================================================================
  // Register offsets
  localparam logic [3:0] REG_CTRL     = 4'h0;
  localparam logic [3:0] REG_TAPSEL   = 4'h1;
  localparam logic [3:0] REG_STATUS   = 4'h2;
  localparam logic [3:0] REG_CNT_LO   = 4'h3;
  localparam logic [3:0] REG_CNT_HI   = 4'h4;

  // ==========================================================================
  // Fields and reset values
  localparam int unsigned CTRL_STOP_BIT = 2;
  localparam logic [7:0]  CTRL_RESET    = 8'h00;
  localparam logic [3:0]  TAPSEL_RESET  = 4'h0;
  localparam logic [3:0]  TAPSEL_MAX    = 4'hb;
  localparam logic [2:0]  MC_LAST       = 3'h5;
  localparam logic [3:0]  WARM_LAST     = 4'h7;

  // ==========================================================================
  // Power state
  typedef enum logic [2:0] {
    SRP_RUN       = 3'b000,
    SRP_HALT_WAIT = 3'b001,
    SRP_STANDBY   = 3'b010,
    SRP_WARMUP    = 3'b011,
    SRP_RESUME    = 3'b100
  } srp_state_e;

endpackage : srp_pkg

// ---- srp_psc_if.sv ----
// Carrier between the power controller and the prescaler.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
`default_nettype none

interface srp_psc_if;
  logic              run;
  logic              stop;
  logic [3:0]        sel;
  logic              mc_tick;
  logic [11:0]       count;
  logic [11:0]       taps;
  logic              ckout;

  modport ctl (output run, output stop, output sel,
               input mc_tick, input count, input taps, input ckout);
  modport psc (input run, input stop, input sel,
               output mc_tick, output count, output taps, output ckout);
endinterface : srp_psc_if

`default_nettype wire

// ---- srp_prescaler.sv ----
// Machine-cycle divider and 12-bit prescaler with tap pulses and clock-output level.
// Assumes run is low whenever the system clock is gated off.
`timescale 1ns/10ps
`default_nettype none

module srp_prescaler
  import srp_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset_n,
  // Controller side
  srp_psc_if.psc    pif
);

  typedef struct packed {
    logic [2:0]        mc_cnt;
    logic              mc_tick;
    logic [PSC_W-1:0]  count;
    logic [PSC_W-1:0]  taps;
    logic              ckout;
  } srp_psc_s;

  srp_psc_s st;
  srp_psc_s next_st;

  // ==========================================================================
  // Next state
  always_comb begin
    logic [PSC_W-1:0] inc;
    inc     = st.count + 12'h001;
    next_st = st;
    next_st.mc_tick = 1'b0;
    next_st.taps    = '0;
    if (pif.stop) begin
      next_st = '0;
    end else if (pif.run) begin
      if (st.mc_cnt == MC_LAST) begin
        next_st.mc_cnt  = 3'h0;
        next_st.mc_tick = 1'b1;
        next_st.count   = inc;
        for (int k = 0; k < PSC_W; k++) begin
          next_st.taps[k] = &(st.count | ~((12'h002 << k) - 12'h001));
        end
        next_st.ckout = inc[pif.sel];
      end else begin
        next_st.mc_cnt = st.mc_cnt + 3'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign pif.mc_tick = st.mc_tick;
  assign pif.count   = st.count;
  assign pif.taps    = st.taps;
  assign pif.ckout   = st.ckout;

endmodule : srp_prescaler

`default_nettype wire

// ---- srp_standby_ctrl.sv ----
// Standby, wake-up and reset control with the prescaler attached.
// Assumes pins are synchronous to clk and that the CPU core obeys hold and resume.
//
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none

module srp_standby_ctrl
  import srp_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              reset_n,
  // CPU core
  input  wire logic              enter_standby_instruction,
  input  wire logic              ext_irq_ack,
  output logic                   sys_clk_enable,
  output logic                   hold_state,
  output logic                   resume_pulse,
  output logic                   cold_start,
  output logic                   ext_irq_pending,
  // Pins and straps
  input  wire logic              oscillator_input_pin,
  input  wire logic              ext_clock_mode,
  input  wire logic              restart_wake_pin,
  input  wire logic              wake_capable_port,
  input  wire logic              external_interrupt_input,
  output logic                   osc_enable,
  output logic                   divided_clock_output_pin,
  // Prescaler taps
  output logic [PSC_W-1:0]       prescaler_taps,
  // Register port
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wr_data,
  input  wire logic              wr_strobe,
  input  wire logic              rd_strobe,
  output logic [DATA_W-1:0]      rd_data
);

  // ==========================================================================
  // State
  typedef struct packed {
    srp_state_e        state;
    logic [3:0]        warm_cnt;
    logic              osc_prev;
    logic              wake_prev;
    logic              irq_prev;
    logic              wake_ok;
    logic              irq_pend;
    logic              resume;
    logic              cold;
    logic              sys_en;
    logic              osc_en;
    logic              hold;
    logic [DATA_W-1:0] ctrl;
    logic [3:0]        tapsel;
    logic [DATA_W-1:0] rdata;
  } srp_ctl_s;

  srp_ctl_s st;
  srp_ctl_s next_st;

  srp_psc_if pif ();

  // ==========================================================================
  // Helpers
  function automatic logic [3:0] clamp_sel(input logic [3:0] v);
    clamp_sel = (v > TAPSEL_MAX) ? TAPSEL_MAX : v;
  endfunction : clamp_sel

  function automatic logic rise(input logic prev, input logic now);
    rise = now & ~prev;
  endfunction : rise

  // ==========================================================================
  // Prescaler
  srp_prescaler u_psc (
    .clk     (clk),
    .reset_n (reset_n),
    .pif     (pif)
  );

  assign pif.run  = st.sys_en;
  assign pif.stop = st.ctrl[CTRL_STOP_BIT];
  assign pif.sel  = st.tapsel;

  // ==========================================================================
  // Next state
  always_comb begin
    logic osc_edge;
    logic wake_edge;
    logic irq_edge;
    osc_edge  = rise(st.osc_prev, oscillator_input_pin);
    wake_edge = rise(st.wake_prev, restart_wake_pin);
    irq_edge  = rise(st.irq_prev, external_interrupt_input);
    next_st   = st;

    // Pin samples run on the free clock, never on the gated one
    next_st.osc_prev  = oscillator_input_pin;
    next_st.wake_prev = restart_wake_pin;
    next_st.irq_prev  = external_interrupt_input;
    next_st.wake_ok   = wake_capable_port;
    next_st.resume    = 1'b0;
    next_st.cold      = 1'b0;

    // Pending interrupt: a new edge beats a same-cycle acknowledge
    if (ext_irq_ack) begin
      next_st.irq_pend = 1'b0;
    end
    if (irq_edge) begin
      next_st.irq_pend = 1'b1;
    end

    unique case (st.state)
      SRP_RUN: begin
        if (enter_standby_instruction) begin
          next_st.state = SRP_HALT_WAIT;
        end
      end
      SRP_HALT_WAIT: begin
        // The halt cycle itself finishes before anything stops; a stopped
        // prescaler gives no machine tick, so halt must not wait for one
        if (pif.mc_tick || pif.stop) begin
          next_st.state  = SRP_STANDBY;
          next_st.sys_en = 1'b0;
          next_st.osc_en = 1'b0;
          next_st.hold   = 1'b1;
        end
      end
      SRP_STANDBY: begin
        // An external source keeps no oscillator of ours; the gate alone stops it
        if (wake_edge && st.wake_ok) begin
          next_st.state    = SRP_WARMUP;
          next_st.osc_en   = 1'b1;
          next_st.warm_cnt = 4'h0;
        end
      end
      SRP_WARMUP: begin
        // An external clock must already toggle here, or warm-up never ends
        if (osc_edge) begin
          if (st.warm_cnt == WARM_LAST) begin
            next_st.state  = SRP_RESUME;
            next_st.sys_en = 1'b1;
          end else begin
            next_st.warm_cnt = st.warm_cnt + 4'h1;
          end
        end
      end
      SRP_RESUME: begin
        next_st.state  = SRP_RUN;
        next_st.hold   = 1'b0;
        next_st.resume = 1'b1;
      end
      default: begin
        next_st.state  = SRP_RUN;
        next_st.sys_en = 1'b1;
        next_st.osc_en = 1'b1;
        next_st.hold   = 1'b0;
      end
    endcase

    // Register writes
    if (wr_strobe) begin
      unique case (addr)
        REG_CTRL:   next_st.ctrl   = wr_data;
        REG_TAPSEL: next_st.tapsel = clamp_sel(wr_data[3:0]);
        default:    next_st.ctrl   = st.ctrl;
      endcase
    end

    // Register reads, answered in the next cycle only
    next_st.rdata = '0;
    if (rd_strobe) begin
      unique case (addr)
        REG_CTRL:   next_st.rdata = st.ctrl;
        REG_TAPSEL: next_st.rdata = {4'h0, st.tapsel};
        REG_STATUS: next_st.rdata = {st.irq_pend, st.wake_ok, ext_clock_mode,
                                     st.hold, st.sys_en, st.state};
        REG_CNT_LO: next_st.rdata = pif.count[7:0];
        REG_CNT_HI: next_st.rdata = {4'h0, pif.count[PSC_W-1:8]};
        default:    next_st.rdata = '0;
      endcase
    end
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st          <= '0;
      st.state    <= SRP_RUN;
      st.sys_en   <= 1'b1;
      st.osc_en   <= 1'b1;
      st.cold     <= 1'b1;
      st.ctrl     <= CTRL_RESET;
      st.tapsel   <= TAPSEL_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================================
  // Outputs
  assign sys_clk_enable           = st.sys_en;
  assign osc_enable               = st.osc_en;
  assign hold_state               = st.hold;
  assign resume_pulse             = st.resume;
  assign cold_start               = st.cold;
  assign ext_irq_pending          = st.irq_pend;
  assign rd_data                  = st.rdata;
  assign prescaler_taps           = pif.taps;
  assign divided_clock_output_pin = pif.ckout;

endmodule : srp_standby_ctrl

`default_nettype wire

// ---- srp_ctrl_checker.sv ----
// Port assertions for the standby, wake and prescaler controller.
// Assumes a bind onto srp_standby_ctrl; one clock domain.
`timescale 1ns/10ps
`default_nettype none
module srp_ctrl_checker
  import srp_pkg::*;
(
  // Clock and reset
  input wire logic              clk,
  input wire logic              reset_n,
  // Observed ports
  input wire logic              sys_clk_enable,
  input wire logic              hold_state,
  input wire logic              resume_pulse,
  input wire logic              cold_start,
  input wire logic              ext_irq_pending,
  input wire logic              oscillator_input_pin,
  input wire logic              restart_wake_pin,
  input wire logic              wake_capable_port,
  input wire logic              external_interrupt_input,
  input wire logic              osc_enable,
  input wire logic              divided_clock_output_pin,
  input wire logic [PSC_W-1:0]  prescaler_taps,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic              wr_strobe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ==========================================================================
  // Helpers: warm-up edge count and a shadow of the stop bit
  logic [3:0] edges;
  logic       osc_q;
  logic       stop_q;
  always_ff @(posedge clk) begin
    osc_q <= oscillator_input_pin;
    if (!reset_n || !osc_enable) edges <= 4'h0;
    else if (!sys_clk_enable && oscillator_input_pin && !osc_q) edges <= edges + 4'h1;
    if (!reset_n) stop_q <= 1'b0;
    else if (wr_strobe && addr == REG_CTRL) stop_q <= wr_data[CTRL_STOP_BIT];
  end
  // ==========================================================================
  // Sequences and properties
  sequence s_edge(logic ok);
    hold_state && !osc_enable && !restart_wake_pin && wake_capable_port == ok
    ##1 restart_wake_pin && wake_capable_port == ok;
  endsequence
  sequence s_resume;
    resume_pulse && !hold_state ##1 !resume_pulse;
  endsequence
  property p_cold; cold_start |-> sys_clk_enable && osc_enable && !hold_state; endproperty
  property p_halt; $rose(hold_state) |-> !sys_clk_enable && !osc_enable; endproperty
  property p_gate; $fell(sys_clk_enable) |-> $rose(hold_state); endproperty
  property p_quiet;
    !sys_clk_enable && !$past(sys_clk_enable)
    |-> $stable(divided_clock_output_pin) && prescaler_taps == '0;
  endproperty
  property p_wake; s_edge(1'b1) |=> osc_enable; endproperty
  property p_refuse; s_edge(1'b0) |=> !osc_enable; endproperty
  property p_warm; $rose(sys_clk_enable) && hold_state |-> edges == 4'h8; endproperty
  property p_resume; $rose(sys_clk_enable) && hold_state |=> s_resume; endproperty
  property p_irq; $rose(external_interrupt_input) |=> ext_irq_pending; endproperty
  property p_stop;
    stop_q && $past(stop_q) |-> prescaler_taps == '0 && !divided_clock_output_pin;
  endproperty
  a_cold: assert property (p_cold) else $error("reset state wrong");
  a_halt: assert property (p_halt) else $error("clock left running");
  a_gate: assert property (p_gate) else $error("gate off outside standby");
  a_quiet: assert property (p_quiet) else $error("activity in standby");
  a_wake: assert property (p_wake) else $error("no oscillator restart");
  a_refuse: assert property (p_refuse) else $error("wake not refused");
  a_warm: assert property (p_warm) else $error("warm-up count wrong");
  a_resume: assert property (p_resume) else $error("resume wrong");
  a_irq: assert property (p_irq) else $error("edge not latched");
  a_stop: assert property (p_stop) else $error("prescaler not silent");
endmodule : srp_ctrl_checker
`default_nettype wire

// ---- srp_osc_model.sv ----
// Oscillator or external clock source at the far side of the controller.
// Assumes pacing by the bench clock; toggles only while run is high.
`timescale 1ns/10ps
`default_nettype none
module srp_osc_model (
  // Clock and enable
  input  wire logic clk,
  input  wire logic run,
  // Oscillator pin
  output var logic  osc_pin
);
  logic div_q;
  initial begin
    osc_pin = 1'b0;
    div_q   = 1'b0;
  end
  // ==========================================================================
  // Stands still while stopped to save power; restarts as soon as run rises,
  // so the source is live before standby is released
  always @(posedge clk) begin
    if (run) begin
      div_q <= !div_q;
      if (div_q) osc_pin <= !osc_pin;
    end
  end
endmodule : srp_osc_model
`default_nettype wire

// ---- standby_reset_prescaler_test.sv ----
// Self-checking bench for the standby, wake and prescaler controller.
// Assumes the checker and oscillator model are compiled first.
`timescale 1ns/10ps
`default_nettype none
module standby_reset_prescaler_test
  import srp_pkg::*;
;
  logic              clk = 1'b0;
  logic              reset_n = 1'b0;
  logic              enter_standby_instruction = 1'b0;
  logic              ext_irq_ack = 1'b0;
  logic              ext_clock_mode = 1'b0;
  logic              restart_wake_pin = 1'b0;
  logic              wake_capable_port = 1'b1;
  logic              external_interrupt_input = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wr_data = '0;
  logic              wr_strobe = 1'b0;
  logic              rd_strobe = 1'b0;
  logic              sys_clk_enable, hold_state, resume_pulse, cold_start;
  logic              ext_irq_pending, oscillator_input_pin, osc_enable;
  logic              divided_clock_output_pin;
  logic [PSC_W-1:0]  prescaler_taps;
  logic [DATA_W-1:0] rd_data;
  logic [5:0]        watch;
  int                mismatches = 0;
  int                tests_run = 0;
  assign watch = {divided_clock_output_pin, prescaler_taps[2:0], resume_pulse, hold_state};
  srp_standby_ctrl u_dut (
    .clk                       (clk),
    .reset_n                   (reset_n),
    .enter_standby_instruction (enter_standby_instruction),
    .ext_irq_ack               (ext_irq_ack),
    .sys_clk_enable            (sys_clk_enable),
    .hold_state                (hold_state),
    .resume_pulse              (resume_pulse),
    .cold_start                (cold_start),
    .ext_irq_pending           (ext_irq_pending),
    .oscillator_input_pin      (oscillator_input_pin),
    .ext_clock_mode            (ext_clock_mode),
    .restart_wake_pin          (restart_wake_pin),
    .wake_capable_port         (wake_capable_port),
    .external_interrupt_input  (external_interrupt_input),
    .osc_enable                (osc_enable),
    .divided_clock_output_pin  (divided_clock_output_pin),
    .prescaler_taps            (prescaler_taps),
    .addr                      (addr),
    .wr_data                   (wr_data),
    .wr_strobe                 (wr_strobe),
    .rd_strobe                 (rd_strobe),
    .rd_data                   (rd_data)
  );
  srp_osc_model u_osc (.clk(clk), .run(osc_enable), .osc_pin(oscillator_input_pin));
  // ==========================================================================
  // Shared tasks
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic conclude();
    if (mismatches == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_strobe <= 1'b1;
    @(posedge clk);
    wr_strobe <= 1'b0;
  endtask : wr
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd_strobe <= 1'b1;
    @(posedge clk);
    rd_strobe <= 1'b0;
    #1;
    check({4'h0, rd_data}, {4'h0, exp});
  endtask : rd_chk
  // Bounded wait; a hang counts as a mismatch and ends the run
  task automatic wait_on(input int sel, input int lim, output int n);
    n = 0;
    do begin
      tick(1);
      n++;
      if (n > lim) begin
        mismatches++;
        conclude();
      end
    end while (watch[sel] !== 1'b1);
  endtask : wait_on
  task automatic standby();
    int n;
    @(posedge clk);
    enter_standby_instruction <= 1'b1;
    @(posedge clk);
    enter_standby_instruction <= 1'b0;
    wait_on(0, 20, n);
    check({sys_clk_enable, osc_enable}, 12'h0);
  endtask : standby
  // ==========================================================================
  // Scenarios
  task automatic t_regs();
    rd_chk(REG_CTRL, CTRL_RESET);
    wr(REG_TAPSEL, 8'h0f);
    rd_chk(REG_TAPSEL, {4'h0, TAPSEL_MAX});
    rd_chk(4'hf, 8'h00);
  endtask : t_regs
  task automatic t_psc();
    int n;
    for (int k = 0; k < 3; k++) begin
      wait_on(2 + k, 100, n);
      wait_on(2 + k, 100, n);
      check(n[11:0], 12'd12 << k);
    end
    wr(REG_CTRL, 8'h04);
    rd_chk(REG_CNT_LO, 8'h00);
    rd_chk(REG_CNT_HI, 8'h00);
    tick(20);
    check({divided_clock_output_pin, prescaler_taps[10:0]}, 12'h0);
    wr(REG_CTRL, 8'h00);
    rd_chk(REG_CNT_LO, 8'h00);
    // First machine tick after release lands six cycles after the write
    tick(4);
    rd_chk(REG_CNT_LO, 8'h01);
    // Tap 0 on the clock-output pin: high one machine cycle, low the next
    wr(REG_TAPSEL, 8'h00);
    wait_on(5, 20, n);
    tick(5);
    check(divided_clock_output_pin, 1'b1);
    tick(1);
    check(divided_clock_output_pin, 1'b0);
  endtask : t_psc
  task automatic t_sleep();
    int n;
    @(posedge clk);
    ext_clock_mode <= 1'b1;
    standby();
    @(posedge clk);
    external_interrupt_input <= 1'b1;
    tick(3);
    check(ext_irq_pending, 1'b1);
    check(prescaler_taps, 12'h0);
    @(posedge clk);
    restart_wake_pin <= 1'b1;
    tick(1);
    check({osc_enable, sys_clk_enable}, 12'h2);
    wait_on(1, 60, n);
    check(n >= 29, 1'b1);
    check({hold_state, sys_clk_enable, ext_irq_pending}, 12'h3);
    rd_chk(REG_STATUS, 8'he8);
    @(posedge clk);
    external_interrupt_input <= 1'b0;
    restart_wake_pin <= 1'b0;
    ext_irq_ack <= 1'b1;
    @(posedge clk);
    ext_irq_ack <= 1'b0;
    tick(1);
    check(ext_irq_pending, 1'b0);
  endtask : t_sleep
  task automatic t_refuse();
    @(posedge clk);
    wake_capable_port <= 1'b0;
    // A stopped prescaler must not keep halt from completing
    wr(REG_CTRL, 8'h04);
    standby();
    @(posedge clk);
    restart_wake_pin <= 1'b1;
    tick(5);
    check(osc_enable, 1'b0);
    @(posedge clk);
    reset_n <= 1'b0;
    restart_wake_pin <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    tick(3);
    check({cold_start, hold_state, sys_clk_enable, osc_enable}, 12'h3);
    rd_chk(REG_CTRL, CTRL_RESET);
  endtask : t_refuse
  // ==========================================================================
  // Clock and main sequence
  initial begin
    forever #25 clk = ~clk;
  end
  initial begin
    repeat (7) @(posedge clk); // held while the oscillator settles
    #1;
    check({cold_start, hold_state, sys_clk_enable, osc_enable}, 12'hb);
    @(posedge clk);
    reset_n <= 1'b1;
    t_regs();
    t_psc();
    t_sleep();
    t_refuse();
    conclude();
  end
endmodule : standby_reset_prescaler_test
bind srp_standby_ctrl srp_ctrl_checker u_chk (.clk, .reset_n, .sys_clk_enable, .hold_state,
  .resume_pulse, .cold_start, .ext_irq_pending, .oscillator_input_pin, .restart_wake_pin,
  .wake_capable_port, .external_interrupt_input, .osc_enable, .divided_clock_output_pin,
  .prescaler_taps, .addr, .wr_data, .wr_strobe);
`default_nettype wire
